// ===== aau_adder.sv
`timescale 1ns/100ps
module aau_adder
  import aau_pkg::*;
(
  input wire logic [7:0] i_a,
  input wire logic [7:0] i_b,
  output logic [7:0] o_sum,
  output logic [4:0] o_flags
);
  logic [8:0] full;
  logic [4:0] low;
  assign full = {1'b0, i_a} + {1'b0, i_b};
  assign low = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]};
  assign o_sum = full[7:0];
  always_comb begin
    o_flags = 5'h00;
    o_flags[FLAG_C] = full[8];
    o_flags[FLAG_DC] = low[4];
    o_flags[FLAG_Z] = (full[7:0] == 8'h00);
    o_flags[FLAG_OV] = (i_a[7] == i_b[7]) && (full[7] != i_a[7]);
    o_flags[FLAG_N] = full[7];
  end
endmodule : aau_adder

// ===== aau_core.sv
`timescale 1ns/100ps
module aau_core
  import aau_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [15:0] i_instr,
  input wire logic i_ext_enable,
  input wire logic [3:0] i_bank_pointer,
  input wire logic [11:0] i_index_base,
  input wire logic [7:0] i_mem_rdata,
  output logic o_busy,
  output logic o_illegal,
  output logic [11:0] o_mem_addr,
  output logic o_mem_rd,
  output logic o_mem_wr,
  output logic [7:0] o_mem_wdata,
  output logic [7:0] o_acc,
  output logic [4:0] o_flags,
  output logic o_done
);
  // --------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------
  function automatic logic is_imm(input logic [15:0] w);
    is_imm = (w[15:8] == OP_ADD_IMM);
  endfunction : is_imm

  function automatic logic is_mem(input logic [15:0] w);
    is_mem = (w[15:10] == OP_ADD_MEM);
  endfunction : is_mem

  aau_phase_e phase;
  logic [15:0] instr;
  logic [7:0] operand;
  logic [7:0] sum;
  logic [4:0] flags_new;
  logic [7:0] result;
  logic [11:0] eff_addr;

  // --------------------------------------------------------------
  // Operand address resolution
  // --------------------------------------------------------------
  // The indexed mode wins over the common bank only for low addresses.
  always_comb begin
    if (instr[BANK_BIT]) begin
      eff_addr = {i_bank_pointer, instr[7:0]};
    end else if (i_ext_enable && instr[7:0] <= IDX_LIMIT) begin
      eff_addr = i_index_base + {4'h0, instr[7:0]};
    end else if (instr[7:0] < ACCESS_SPLIT) begin
      eff_addr = {ACCESS_LOW_BANK, instr[7:0]};
    end else begin
      eff_addr = {ACCESS_HIGH_BANK, instr[7:0]};
    end
  end

  aau_adder u_adder (
    .i_a(o_acc),
    .i_b(operand),
    .o_sum(sum),
    .o_flags(flags_new)
  );

  // --------------------------------------------------------------
  // Phase sequencer
  // --------------------------------------------------------------
  // A new instruction is only taken in decode, so starts while busy
  // are ignored rather than queued.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      phase <= AAU_DECODE;
      instr <= 16'h0000;
      o_illegal <= 1'b0;
    end else begin
      unique case (phase)
        AAU_DECODE: begin
          o_illegal <= 1'b0;
          if (i_start) begin
            if (is_imm(i_instr) || is_mem(i_instr)) begin
              instr <= i_instr;
              phase <= AAU_READ;
            end else begin
              o_illegal <= 1'b1;
            end
          end
        end
        AAU_READ: phase <= AAU_PROCESS;
        AAU_PROCESS: phase <= AAU_WRITE;
        AAU_WRITE: phase <= AAU_DECODE;
        default: phase <= AAU_DECODE;
      endcase
    end
  end

  // --------------------------------------------------------------
  // Read, add and write
  // --------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      operand <= 8'h00;
    end else if (phase == AAU_READ) begin
      operand <= is_imm(instr) ? instr[7:0] : i_mem_rdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      result <= 8'h00;
    end else if (phase == AAU_PROCESS) begin
      result <= sum;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_flags <= 5'h00;
    end else if (phase == AAU_PROCESS) begin
      o_flags <= flags_new;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_acc <= ACC_RESET;
    end else if (phase == AAU_WRITE) begin
      if (is_imm(instr) || !instr[DEST_BIT]) begin
        o_acc <= result;
      end
    end
  end

  // Memory strobes are combinational so the byte arrives by the next edge.
  assign o_mem_addr = eff_addr;
  assign o_mem_rd = (phase == AAU_READ) && is_mem(instr);
  assign o_mem_wr = (phase == AAU_WRITE) && is_mem(instr)
                    && instr[DEST_BIT];
  assign o_mem_wdata = result;
  assign o_done = (phase == AAU_WRITE);
  assign o_busy = (phase != AAU_DECODE);

  // --------------------------------------------------------------
  // Check helpers
  // --------------------------------------------------------------
  // A second adder, kept apart from the datapath one, so that the flag
  // checks below do not simply restate the logic that they watch.
  logic [7:0] chk_sum;
  logic [4:0] chk_low;
  assign chk_sum = o_acc + operand;
  assign chk_low = {1'b0, o_acc[3:0]} + {1'b0, operand[3:0]};

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  a_phase_order: assert property (@(posedge i_clk) disable iff (i_rst)
    (phase == AAU_DECODE && $past(phase) == AAU_DECODE && i_start
     && (is_imm(i_instr) || is_mem(i_instr)))
    |=> o_busy ##1 o_busy ##1 o_done ##1 !o_busy)
    else $error("phase order broken");
  a_imm_sum: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_done && is_imm(instr))
    |=> o_acc == $past(o_acc) + $past(operand))
    else $error("immediate sum not written");
  a_imm_literal: assert property (@(posedge i_clk) disable iff (i_rst)
    (phase == AAU_READ && is_imm(instr)) |=> operand == instr[7:0])
    else $error("literal not used");
  a_mem_flags: assert property (@(posedge i_clk) disable iff (i_rst)
    (phase == AAU_PROCESS && is_mem(instr))
    |=> o_flags[FLAG_C] == ({1'b0, $past(o_acc)} + {1'b0, $past(operand)}
        > 9'h0ff))
    else $error("carry flag wrong");
  a_dest_acc: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_done && is_mem(instr) && !instr[DEST_BIT]) |-> !o_mem_wr)
    else $error("write to memory with accumulator destination");
  a_dest_mem: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_done && is_mem(instr) && instr[DEST_BIT])
    |-> o_mem_wr ##1 $stable(o_acc))
    else $error("memory destination mishandled");
  a_access_bank: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_mem_rd && !instr[BANK_BIT] && !i_ext_enable)
    |-> o_mem_addr[11:8] == (instr[7] ? ACCESS_HIGH_BANK
                                      : ACCESS_LOW_BANK))
    else $error("access bank address wrong");
  a_bank_ptr: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_mem_rd && instr[BANK_BIT]) |-> o_mem_addr[11:8] == i_bank_pointer)
    else $error("bank pointer not used");
  a_indexed: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_mem_rd && !instr[BANK_BIT] && i_ext_enable && instr[7:0] <= IDX_LIMIT)
    |-> o_mem_addr == i_index_base + {4'h0, instr[7:0]})
    else $error("indexed address wrong");
  a_zero_flag: assert property (@(posedge i_clk) disable iff (i_rst)
    (phase == AAU_PROCESS) |=> o_flags[FLAG_Z] == (chk_sum == 8'h00))
    else $error("zero flag wrong");
  a_neg_flag: assert property (@(posedge i_clk) disable iff (i_rst)
    (phase == AAU_PROCESS) |=> o_flags[FLAG_N] == chk_sum[7])
    else $error("negative flag wrong");
  a_over_flag: assert property (@(posedge i_clk) disable iff (i_rst)
    (phase == AAU_PROCESS) |=> o_flags[FLAG_OV]
      == (o_acc[7] == operand[7] && chk_sum[7] != o_acc[7]))
    else $error("overflow flag wrong");
  a_digit_flag: assert property (@(posedge i_clk) disable iff (i_rst)
    (phase == AAU_PROCESS) |=> o_flags[FLAG_DC] == chk_low[4])
    else $error("digit carry flag wrong");
  a_illegal_op: assert property (@(posedge i_clk) disable iff (i_rst)
    (phase == AAU_DECODE && i_start && !is_imm(i_instr) && !is_mem(i_instr))
    |=> o_illegal && !o_busy)
    else $error("unknown opcode not flagged");
  a_imm_no_mem: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_busy && is_imm(instr)) |-> !o_mem_rd && !o_mem_wr)
    else $error("immediate add touched memory");
  a_mem_wdata: assert property (@(posedge i_clk) disable iff (i_rst)
    o_mem_wr |-> o_mem_wdata == chk_sum)
    else $error("memory write data wrong");
  a_reset_idle: assert property (@(posedge i_clk)
    $fell(i_rst) |-> !o_busy && o_acc == ACC_RESET && o_flags == 5'h00)
    else $error("outputs not idle after reset");
  a_acc_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    (phase != AAU_WRITE) |=> $stable(o_acc))
    else $error("accumulator changed outside write phase");
  c_imm: cover property (@(posedge i_clk) o_done && is_imm(instr));
  c_mem_to_mem: cover property (@(posedge i_clk) o_mem_wr);
  c_indexed: cover property (@(posedge i_clk)
    o_mem_rd && i_ext_enable && !instr[BANK_BIT] && instr[7:0] <= IDX_LIMIT);
  c_mem_to_acc: cover property (@(posedge i_clk)
    o_done && is_mem(instr) && !instr[DEST_BIT]);
  c_zero_result: cover property (@(posedge i_clk) o_done && result == 8'h00);
endmodule : aau_core

// ===== aau_mem_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Banked data memory seen by the add unit.
// ----------------------------------------------------------------
module aau_mem_model (
  input wire logic i_clk,
  input wire logic [11:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [4096];
  logic [7:0] last;
  // Outside a read the bus shows the inverse of the last byte, so a core
  // that samples in the wrong cycle cannot pass by luck.
  assign o_rdata = i_rd ? mem[i_addr] : ~last;
  initial begin
    last = 8'h00;
    for (int i = 0; i < 4096; i++)
      mem[i] = i[7:0] ^ 8'ha5;
  end
  always @(posedge i_clk) begin
    if (i_rd)
      last <= mem[i_addr];
    if (i_wr)
      mem[i_addr] <= i_wdata;
  end
endmodule : aau_mem_model

// ===== aau_pkg.sv
//
// Contract
// - Immediate add: literal plus accumulator, five flags.
// - Memory add: accumulator plus byte, five flags.
// - Destination bit zero accumulator, one memory.
// - Bank bit zero uses common access bank.
// - Bank bit one uses bank pointer.
// - Extended set, low address: indexed literal offset.
package aau_pkg;
  localparam logic [7:0] OP_ADD_IMM = 8'h0f;
  localparam logic [5:0] OP_ADD_MEM = 6'h09;
  localparam int DEST_BIT = 9;
  localparam int BANK_BIT = 8;
  localparam logic [7:0] IDX_LIMIT = 8'h5f;
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam int FLAG_C = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_N = 4;
  typedef enum logic [3:0] {
    AAU_DECODE = 4'h1,
    AAU_READ = 4'h2,
    AAU_PROCESS = 4'h4,
    AAU_WRITE = 4'h8
  } aau_phase_e;
endpackage : aau_pkg

// ===== accumulator_add_unit_tb_top.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Self-checking bench for the add unit.
// ----------------------------------------------------------------
module accumulator_add_unit_tb_top;
  import aau_pkg::*;
  logic i_clk = 1'b0, i_rst = 1'b1, i_start = 1'b0, i_ext_enable = 1'b0;
  logic [15:0] i_instr = 16'h0000;
  logic [3:0] i_bank_pointer = 4'h0;
  logic [11:0] i_index_base = 12'h000, o_mem_addr;
  logic [7:0] i_mem_rdata, o_mem_wdata, o_acc, acc = 8'h00;
  logic o_busy, o_illegal, o_mem_rd, o_mem_wr, o_done;
  logic [4:0] o_flags;
  int fails = 0, n_checks = 0;
  aau_core dut (.i_clk(i_clk), .i_rst(i_rst), .i_start(i_start),
    .i_instr(i_instr), .i_ext_enable(i_ext_enable),
    .i_bank_pointer(i_bank_pointer), .i_index_base(i_index_base),
    .i_mem_rdata(i_mem_rdata), .o_busy(o_busy), .o_illegal(o_illegal),
    .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
    .o_mem_wdata(o_mem_wdata), .o_acc(o_acc), .o_flags(o_flags),
    .o_done(o_done));
  aau_mem_model mem (.i_clk(i_clk), .i_addr(o_mem_addr), .i_rd(o_mem_rd),
    .i_wr(o_mem_wr), .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));
  initial begin
    forever #20 i_clk = ~i_clk;
  end
  task automatic check(string what, logic [11:0] seen, logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic check_idle();
    check("idle busy", o_busy, 1'b0);
    check("idle acc", o_acc, ACC_RESET);
    check("idle flags", o_flags, 5'h00);
    check("idle strobes", {o_mem_rd, o_mem_wr, o_done}, 3'h0);
  endtask : check_idle
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  function automatic logic [4:0] flg(logic [7:0] a, logic [7:0] b);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, b};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    return {s[7], a[7] == b[7] && s[7] != a[7], s[7:0] == 8'h00, h[4], s[8]};
  endfunction : flg
  // Issues one instruction; the operand is the literal or the memory byte.
  task automatic run(logic [15:0] w, logic [11:0] ea, logic mem_op);
    logic [7:0] b;
    int n;
    b = mem_op ? (ea[7:0] ^ 8'ha5) : w[7:0];
    @(posedge i_clk);
    i_start <= 1'b1;
    i_instr <= w;
    @(posedge i_clk);
    i_start <= 1'b0;
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
      if (n == 1) begin
        check("read strobe", o_mem_rd, mem_op);
        check("busy", o_busy, 1'b1);
      end
    end while (o_done !== 1'b1 && n < 8);
    check("done cycle", n, 3);
    check("mem write", o_mem_wr, mem_op & w[DEST_BIT]);
    if (mem_op) begin
      check("address", o_mem_addr, ea);
      if (w[DEST_BIT])
        check("write data", o_mem_wdata, 8'(acc + b));
    end
    @(negedge i_clk);
    check("flags", o_flags, flg(acc, b));
    if (!mem_op || !w[DEST_BIT])
      acc = acc + b;
    check("acc", o_acc, acc);
    check("done pulse", o_done, 1'b0);
    check("busy end", o_busy, 1'b0);
    @(posedge i_clk);
  endtask : run
  initial begin
    repeat (2000) @(posedge i_clk);
    fails++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    @(negedge i_clk);
    check_idle();
    run(16'h0f10, 12'h000, 1'b0);
    run(16'h0f15, 12'h000, 1'b0);
    run(16'h0f5b, 12'h000, 1'b0);
    i_bank_pointer <= 4'h3;
    run(16'h2540, 12'h340, 1'b1);
    i_ext_enable <= 1'b1;
    i_index_base <= 12'h123;
    run(16'h26c2, 12'hfc2, 1'b1);
    run(16'h245f, 12'h182, 1'b1);
    i_ext_enable <= 1'b0;
    run(16'h2420, 12'h020, 1'b1);
    run(16'h27ff, 12'h3ff, 1'b1);
    run(16'h0fef, 12'h000, 1'b0);
    // A start held high while busy must be dropped, not queued.
    @(posedge i_clk);
    i_start <= 1'b1;
    i_instr <= 16'h0f01;
    @(posedge i_clk);
    i_instr <= 16'h0f02;
    @(posedge i_clk);
    i_start <= 1'b0;
    repeat (3) @(negedge i_clk);
    acc = acc + 8'h01;
    check("start while busy", o_acc, acc);
    check("busy after refused", o_busy, 1'b0);
    // Reset in the middle of an instruction aborts it.
    @(posedge i_clk);
    i_start <= 1'b1;
    i_instr <= 16'h0f01;
    @(posedge i_clk);
    i_start <= 1'b0;
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    @(negedge i_clk);
    acc = ACC_RESET;
    check_idle();
    run(16'h0f00, 12'h000, 1'b0);
    @(posedge i_clk);
    i_start <= 1'b1;
    i_instr <= 16'hffff;
    @(posedge i_clk);
    i_start <= 1'b0;
    @(negedge i_clk);
    check("illegal", o_illegal, 1'b1);
    check("illegal busy", o_busy, 1'b0);
    conclude();
  end
endmodule : accumulator_add_unit_tb_top
